/* rsc_pkg.sv */
package rsc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_WAIT_SEL = 12'h000; // stabilise_wait_select
  localparam logic [11:0] OFS_CAUSE = 12'h004;    // reset_cause_flags, read only
  localparam logic [11:0] OFS_WATCH = 12'h008;    // clock_watch_mode
  localparam logic [11:0] OFS_STATUS = 12'h00c;   // Standby and reset state, read only

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CAUSE_WDT_BIT = 0;            // Watchdog overflow caused reset
  localparam int CAUSE_CLKW_BIT = 1;           // clock_watch_reset_flag
  localparam int CAUSE_LVI_BIT = 2;            // low_voltage_detector caused reset
  localparam int WATCH_EN_BIT = 0;             // clock_watch_enable
  localparam logic [2:0] WAIT_SEL_RST = 3'h4;  // Longest wait after reset
  localparam logic [2:0] WAIT_SEL_MAX = 3'h4;  // Highest legal selection
  localparam logic [2:0] CAUSE_RST = 3'h0;     // Flags after power-up
  localparam int STAB_BASE_SHIFT = 8;          // Wait is 2^(8+sel) cycles
  localparam int CNT_W = 13;                   // Holds 2^12 at most

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;           // 25 MHz system clock
  localparam int RST_STRETCH_NS = 160;         // Internal reset outlasts its cause
  localparam logic [2:0] RST_HOLD_CYC = 3'((RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // Standby modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,   // CPU clocked
    MODE_HALT = 3'b001,  // CPU halted, oscillators on
    MODE_STOP = 3'b010,  // Oscillators off
    MODE_OSCW = 3'b011,  // Oscillator started, not yet running
    MODE_STAB = 3'b100   // Counting stabilisation wait
  } rsc_mode_e;

  // Input synchroniser bit order
  localparam int SY_PIN = 0;
  localparam int SY_WDT = 1;
  localparam int SY_CLKF = 2;
  localparam int SY_LVI = 3;
  localparam int SY_POC = 4;
  localparam int SY_OSC = 5;
  localparam logic [5:0] SYNC_RST = 6'h01;     // Reset pin idles high

  typedef struct packed {
    logic [5:0] sync1;        // First synchroniser stage
    logic [5:0] sync2;        // Second synchroniser stage
    rsc_mode_e mode;          // Standby mode
    logic [CNT_W-1:0] cnt;    // Stabilisation counter
    logic [2:0] hold;         // Reset stretch counter
    logic in_rst;             // Internal reset active
    logic by_lvi;             // Current reset includes low voltage
    logic retain;             // Reset arrived during STOP
    logic [2:0] wait_sel;     // stabilise_wait_select
    logic [2:0] cause;        // reset_cause_flags
    logic watch_en;           // clock_watch_enable
    logic wdt_clr;            // Watchdog re-initialise
    logic lvi_clr;            // Low-voltage detector re-initialise
    logic xtal_en;            // crystal_clock_input oscillator enable
    logic iosc_en;            // Internal oscillator enable
    logic cpu_en;             // CPU clock enable
    logic port_hiz;           // Ports float
    logic low_oe;             // reset_low_drive_pin enable
    logic low_o;              // reset_low_drive_pin level
    logic pready;             // APB ready
    logic pslverr;            // APB error
    logic [31:0] prdata;      // APB read data
  } rsc_state_s;

endpackage

/* rsc_top.sv */
`timescale 1ns/10ps
module rsc_top (
  input wire logic CLK,                 // System clock, 25 MHz
  input wire logic NRST,                // Power-up reset, async, active low
  input wire logic RESET_IN_N,          // External reset pin
  input wire logic WDT_OVF,             // Watchdog overflow
  input wire logic CLK_FAIL,            // Clock monitor detects stopped clock
  input wire logic LVI_DET,             // low_voltage_detector reset request
  input wire logic POC_DET,             // power_on_clear reset request
  input wire logic OSC_OK,              // Oscillator has started running
  input wire logic STOP_EXEC,           // CPU executes STOP
  input wire logic HALT_EXEC,           // CPU executes HALT
  input wire logic [7:0] IRQ_REQ,       // Interrupt request flags
  input wire logic [7:0] IRQ_MASK,      // Interrupt mask flags, 1 masks
  input wire logic PSEL,                // APB select
  input wire logic PENABLE,             // APB enable
  input wire logic PWRITE,              // APB direction
  input wire logic [11:0] PADDR,        // APB byte address
  input wire logic [31:0] PWDATA,       // APB write data
  output logic [31:0] PRDATA,           // APB read data
  output logic PREADY,                  // APB ready
  output logic PSLVERR,                 // APB error on unmapped address
  output logic SYS_RST_N,               // Merged internal reset
  output logic CPU_CLK_EN,              // CPU clock running
  output logic XTAL_EN,                 // Crystal oscillator enable
  output logic INT_OSC_EN,              // Internal oscillator enable
  output logic RETAIN_HOLD,             // Keep STOP contents through reset
  output logic PORT_HIZ,                // All ports float
  output logic LOW_PIN_O,               // reset_low_drive_pin output level
  output logic LOW_PIN_OE,              // reset_low_drive_pin output enable
  output logic WDT_CLEAR,               // Re-initialise watchdog
  output logic LVI_CLEAR                // Re-initialise low-voltage detector
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int CNT_W_L = rsc_pkg::CNT_W; // Counter width, local copy
  rsc_pkg::rsc_state_s s;       // Registered state
  rsc_pkg::rsc_state_s next_s;  // Next state
  logic pin_rst;                // Synchronised pin reset
  logic wdt_rst;                // Synchronised watchdog request
  logic clkw_rst;               // Clock watch request, only when enabled
  logic lvi_rst;                // Synchronised low-voltage request
  logic poc_rst;                // Synchronised power-on clear
  logic osc_run;                // Synchronised oscillator running
  logic req;                    // Any reset source
  logic pend;                   // Unmasked interrupt pending
  logic setup;                  // APB setup cycle
  logic wr_acc;                 // APB write completes
  logic [CNT_W_L-1:0] limit;    // Stabilisation target

  // ----------------------------------------------------------------
  // Source decode
  // ----------------------------------------------------------------
  always_comb begin
    // Reset pin is active low
    pin_rst = ~s.sync2[rsc_pkg::SY_PIN];
    wdt_rst = s.sync2[rsc_pkg::SY_WDT];
    // Clock watch only resets while it is enabled
    clkw_rst = s.sync2[rsc_pkg::SY_CLKF] & s.watch_en;
    lvi_rst = s.sync2[rsc_pkg::SY_LVI];
    poc_rst = s.sync2[rsc_pkg::SY_POC];
    osc_run = s.sync2[rsc_pkg::SY_OSC];
    req = pin_rst | wdt_rst | clkw_rst | lvi_rst | poc_rst;
    pend = |(IRQ_REQ & ~IRQ_MASK);
    setup = PSEL & ~PENABLE;
    wr_acc = PSEL & PENABLE & s.pready & PWRITE & ~s.pslverr;
    limit = CNT_W_L'(1) << (rsc_pkg::STAB_BASE_SHIFT + int'(s.wait_sel));
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    // Two-stage synchronisers for the reset sources and OSC_OK
    next_s.sync1 = {OSC_OK, POC_DET, LVI_DET, CLK_FAIL, WDT_OVF, RESET_IN_N};
    next_s.sync2 = s.sync1;

    // Software writes; the reset path below overrides them
    if (wr_acc) begin
      if (PADDR == rsc_pkg::OFS_WAIT_SEL && PWDATA[2:0] <= rsc_pkg::WAIT_SEL_MAX) begin
        next_s.wait_sel = PWDATA[2:0];
      end
      if (PADDR == rsc_pkg::OFS_WATCH && PWDATA[rsc_pkg::WATCH_EN_BIT]) begin
        next_s.watch_en = 1'b1;
      end
    end

    // Cause flags, power-on clear wins over every set
    if (wdt_rst) begin
      next_s.cause[rsc_pkg::CAUSE_WDT_BIT] = 1'b1;
    end
    if (clkw_rst) begin
      next_s.cause[rsc_pkg::CAUSE_CLKW_BIT] = 1'b1;
    end
    if (lvi_rst) begin
      next_s.cause[rsc_pkg::CAUSE_LVI_BIT] = 1'b1;
    end
    if (poc_rst) begin
      next_s.cause = rsc_pkg::CAUSE_RST;
    end

    if (req) begin
      // Assert at once and restart the stretch; mode is frozen
      next_s.in_rst = 1'b1;
      next_s.hold = rsc_pkg::RST_HOLD_CYC;
      next_s.watch_en = 1'b0;
      next_s.wait_sel = rsc_pkg::WAIT_SEL_RST;
      if (lvi_rst) begin
        next_s.by_lvi = 1'b1;
      end
      if (s.mode == rsc_pkg::MODE_STOP) begin
        next_s.retain = 1'b1;
      end
    end else if (s.in_rst) begin
      // Synchronous release once the stretch has run out
      if (s.hold != 3'h0) begin
        next_s.hold = s.hold - 3'h1;
      end else begin
        next_s.in_rst = 1'b0;
        next_s.by_lvi = 1'b0;
        next_s.retain = 1'b0;
        next_s.mode = rsc_pkg::MODE_OSCW;
      end
    end else begin
      unique case (s.mode)
        rsc_pkg::MODE_RUN: begin
          // STOP wins over HALT when both arrive together
          if (STOP_EXEC && pend) begin
            next_s.mode = rsc_pkg::MODE_STAB;
            next_s.cnt = '0;
          end else if (STOP_EXEC) begin
            next_s.mode = rsc_pkg::MODE_STOP;
          end else if (HALT_EXEC && !pend) begin
            next_s.mode = rsc_pkg::MODE_HALT;
          end
        end
        rsc_pkg::MODE_HALT: begin
          // Any unmasked request resumes the CPU
          if (pend) begin
            next_s.mode = rsc_pkg::MODE_RUN;
          end
        end
        rsc_pkg::MODE_STOP: begin
          // Wake restarts the oscillator first
          if (pend) begin
            next_s.mode = rsc_pkg::MODE_OSCW;
          end
        end
        rsc_pkg::MODE_OSCW: begin
          // Start-up time is not part of the wait
          if (osc_run) begin
            next_s.mode = rsc_pkg::MODE_STAB;
            next_s.cnt = '0;
          end
        end
        rsc_pkg::MODE_STAB: begin
          // Count up to the selected power of two
          if (s.cnt == limit - CNT_W_L'(1)) begin
            next_s.mode = rsc_pkg::MODE_RUN;
          end else begin
            next_s.cnt = s.cnt + CNT_W_L'(1);
          end
        end
        default: begin
          // Illegal codes fall back to running
          next_s.mode = rsc_pkg::MODE_RUN;
        end
      endcase
    end

    // Outputs follow the next state so each leaves a flip-flop
    next_s.xtal_en = ~next_s.in_rst & (next_s.mode != rsc_pkg::MODE_STOP);
    next_s.iosc_en = ~next_s.in_rst & (next_s.mode != rsc_pkg::MODE_STOP);
    next_s.cpu_en = ~next_s.in_rst & (next_s.mode == rsc_pkg::MODE_RUN);
    next_s.port_hiz = next_s.in_rst;
    next_s.low_oe = next_s.in_rst;
    next_s.low_o = 1'b0;
    next_s.wdt_clr = next_s.in_rst;
    next_s.lvi_clr = next_s.in_rst & ~next_s.by_lvi;

    // APB: answer captured in setup, ready during access
    next_s.pready = setup;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h0000_0000;
    if (setup) begin
      unique case (PADDR)
        rsc_pkg::OFS_WAIT_SEL: next_s.prdata = {29'h0, s.wait_sel};
        rsc_pkg::OFS_CAUSE: next_s.prdata = {29'h0, s.cause};
        rsc_pkg::OFS_WATCH: next_s.prdata = {31'h0, s.watch_en};
        rsc_pkg::OFS_STATUS: next_s.prdata = {27'h0, s.in_rst, s.retain, s.mode};
        // Unmapped offsets answer with an error
        default: next_s.pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      s <= '{sync1: rsc_pkg::SYNC_RST, sync2: rsc_pkg::SYNC_RST, mode: rsc_pkg::MODE_RUN,
             cnt: '0, hold: rsc_pkg::RST_HOLD_CYC, in_rst: 1'b1, by_lvi: 1'b0, retain: 1'b0,
             wait_sel: rsc_pkg::WAIT_SEL_RST, cause: rsc_pkg::CAUSE_RST, watch_en: 1'b0,
             wdt_clr: 1'b1, lvi_clr: 1'b1, xtal_en: 1'b0, iosc_en: 1'b0, cpu_en: 1'b0,
             port_hiz: 1'b1, low_oe: 1'b1, low_o: 1'b0, pready: 1'b0, pslverr: 1'b0,
             prdata: 32'h0000_0000};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    PRDATA = s.prdata;
    PREADY = s.pready;
    PSLVERR = s.pslverr;
    SYS_RST_N = ~s.in_rst;
    CPU_CLK_EN = s.cpu_en;
    XTAL_EN = s.xtal_en;
    INT_OSC_EN = s.iosc_en;
    RETAIN_HOLD = s.retain;
    PORT_HIZ = s.port_hiz;
    LOW_PIN_O = s.low_o;
    LOW_PIN_OE = s.low_oe;
    WDT_CLEAR = s.wdt_clr;
    LVI_CLEAR = s.lvi_clr;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);

  // Pin and oscillator state while reset is active

  osc_stopped_a: assert property (!SYS_RST_N |-> !XTAL_EN && !INT_OSC_EN)
    else $error("Oscillator enabled during reset");
  port_safe_a: assert property (!SYS_RST_N |-> PORT_HIZ && LOW_PIN_OE && !LOW_PIN_O)
    else $error("Ports not safe during reset");
  // Cause flags and clock watch enable
  poc_clear_a: assert property (poc_rst |=> s.cause == 3'h0)
    else $error("Cause flags not cleared by power-on clear");
  watch_sticky_a: assert property (s.watch_en && !req |=> s.watch_en)
    else $error("Clock watch enable dropped without reset");
  watch_reset_a: assert property (clkw_rst |=> s.cause[1] && !s.watch_en)
    else $error("Clock watch reset did not set flag and clear enable");
  // Re-initialise requests to the watchdog and detector
  wdt_clear_a: assert property (wdt_rst |=> WDT_CLEAR ##1 WDT_CLEAR)
    else $error("Watchdog not re-initialised");
  lvi_keep_a: assert property (lvi_rst |=> !LVI_CLEAR)
    else $error("Detector re-initialised by its own reset");
  // Standby entry and exit, STOP retention and reset merging
  halt_exit_a: assert property (s.mode == rsc_pkg::MODE_HALT && pend && !req && !s.in_rst
    |=> s.mode == rsc_pkg::MODE_RUN)
    else $error("Standby not left with pending interrupt");
  stop_degrade_a: assert property (s.mode == rsc_pkg::MODE_RUN && STOP_EXEC && pend && !req && !s.in_rst
    |=> s.mode == rsc_pkg::MODE_STAB && XTAL_EN)
    else $error("STOP with pending interrupt did not degrade");
  osc_wait_a: assert property (s.mode == rsc_pkg::MODE_OSCW && !osc_run && !req
    |=> s.mode == rsc_pkg::MODE_OSCW && s.cnt == $past(s.cnt))
    else $error("Wait counted before oscillator ran");
  retain_a: assert property (s.mode == rsc_pkg::MODE_STOP && req |=> RETAIN_HOLD && !SYS_RST_N)
    else $error("STOP contents not held through reset");
  rst_merge_a: assert property (req |=> !SYS_RST_N ##1 !SYS_RST_N)
    else $error("Reset source not merged");

  // Stabilisation wait, wake paths and reset release
  wait_done_a: assert property (s.mode == rsc_pkg::MODE_STAB && s.cnt == limit - CNT_W_L'(1)
    && !req && !s.in_rst |=> CPU_CLK_EN && s.mode == rsc_pkg::MODE_RUN)
    else $error("CPU not released after stabilisation wait");
  stop_wake_a: assert property (s.mode == rsc_pkg::MODE_STOP && pend && !req && !s.in_rst
    |=> s.mode == rsc_pkg::MODE_OSCW && XTAL_EN)
    else $error("STOP not left on pending interrupt");
  halt_block_a: assert property (s.mode == rsc_pkg::MODE_RUN && HALT_EXEC && !STOP_EXEC && pend
    && !req && !s.in_rst |=> s.mode == rsc_pkg::MODE_RUN)
    else $error("HALT entered with pending interrupt");
  retain_keep_a: assert property (s.retain && (req || s.hold != 3'h0)
    |=> RETAIN_HOLD && !SYS_RST_N && s.mode == rsc_pkg::MODE_STOP)
    else $error("STOP contents lost during reset");
  rst_release_a: assert property (s.in_rst && !req && s.hold == 3'h0
    |=> SYS_RST_N && s.mode == rsc_pkg::MODE_OSCW)
    else $error("Reset not released after stretch");

endmodule

/* rsc_src_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Reset sources and oscillator seen from outside the block
// ----------------------------------------
module rsc_src_model #(
  parameter int OSC_START_CYC = 20, // Oscillator start-up interval in cycles
  parameter int PIN_MIN_CYC = 250   // Shortest pin reset, 10 us at 25 MHz
) (
  input wire logic clk,      // System clock
  input wire logic xtal_en,  // Oscillator enable from the block
  output logic reset_in_n,   // External reset pin
  output logic wdt_ovf,      // Watchdog overflow
  output logic clk_fail,     // Clock monitor fail
  output logic lvi_det,      // Low-voltage request
  output logic poc_det,      // Power-on-clear request
  output logic osc_ok        // Oscillator running
);
  int unsigned ocnt; // Start-up counter

  // All sources idle at time zero
  initial begin
    reset_in_n = 1'b1;
    {wdt_ovf, clk_fail, lvi_det, poc_det, osc_ok} = 5'h00;
    ocnt = 0;
  end

  // Oscillator only runs some cycles after it is enabled
  always @(posedge clk) begin
    if (!xtal_en) begin
      ocnt <= 0;
      osc_ok <= 1'b0;
    end else if (ocnt < OSC_START_CYC) begin
      ocnt <= ocnt + 1;
    end else begin
      osc_ok <= 1'b1;
    end
  end

  // Drive one source: 0 pin, 1 watchdog, 2 clock fail, 3 low voltage, 4 power-on clear
  task automatic set_src(input int src, input logic v);
    case (src)
      0: reset_in_n <= ~v;
      1: wdt_ovf <= v;
      2: clk_fail <= v;
      3: lvi_det <= v;
      default: poc_det <= v;
    endcase
  endtask

  // Hold one source active for a number of cycles
  task automatic fire(input int src, input int cyc);
    int n;
    n = (src == 0 && cyc < PIN_MIN_CYC) ? PIN_MIN_CYC : cyc;
    @(posedge clk);
    set_src(src, 1'b1);
    repeat (n) @(posedge clk);
    set_src(src, 1'b0);
  endtask
endmodule

/* reset_standby_control_tb.sv */
`timescale 1ns/10ps
module reset_standby_control_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int OSC = 20; // Oscillator start-up in the model
  logic clk = 1'b0, nrst, stop_exec, halt_exec, psel, penable, pwrite;
  logic [7:0] irq_req, irq_mask;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, last_rd;
  logic pready, pslverr, last_err, sys_rst_n, cpu_clk_en, xtal_en, int_osc_en, retain_hold;
  logic port_hiz, low_pin_o, low_pin_oe, wdt_clear, lvi_clear;
  logic reset_in_n, wdt_ovf, clk_fail, lvi_det, poc_det, osc_ok;
  int fail_count = 0, tests_run = 0;

  always #20 clk = ~clk;

  rsc_top u_dut (.CLK(clk), .NRST(nrst), .RESET_IN_N(reset_in_n), .WDT_OVF(wdt_ovf), .CLK_FAIL(clk_fail),
    .LVI_DET(lvi_det), .POC_DET(poc_det), .OSC_OK(osc_ok), .STOP_EXEC(stop_exec), .HALT_EXEC(halt_exec),
    .IRQ_REQ(irq_req), .IRQ_MASK(irq_mask), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SYS_RST_N(sys_rst_n),
    .CPU_CLK_EN(cpu_clk_en), .XTAL_EN(xtal_en), .INT_OSC_EN(int_osc_en), .RETAIN_HOLD(retain_hold),
    .PORT_HIZ(port_hiz), .LOW_PIN_O(low_pin_o), .LOW_PIN_OE(low_pin_oe), .WDT_CLEAR(wdt_clear),
    .LVI_CLEAR(lvi_clear));

  rsc_src_model #(.OSC_START_CYC(OSC)) u_src (.clk(clk), .xtal_en(xtal_en), .reset_in_n(reset_in_n),
    .wdt_ovf(wdt_ovf), .clk_fail(clk_fail), .lvi_det(lvi_det), .poc_det(poc_det), .osc_ok(osc_ok));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // One APB transfer; setup, then access until ready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      $display("BAD %0t no APB ready", $time);
    end
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // CPU instruction pulse, STOP when stop is set, HALT otherwise
  task automatic pulse(input logic stop);
    @(posedge clk);
    if (stop) stop_exec <= 1'b1;
    else halt_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0; halt_exec <= 1'b0;
  endtask

  // Wait for the CPU clock to come back and count the cycles
  task automatic wait_cpu(input int lim, output int n);
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Oscillator enable up, then start-up plus stabilisation wait
  task automatic boot(input int w);
    int n, m;
    n = 0;
    while (xtal_en !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    wait_cpu(6000, m);
    chk(m >= OSC + w && m <= OSC + w + 8, 1'b1, "wait from oscillator start");
  endtask

  // One reset episode from a source, with checks while it is active
  task automatic episode(input int src, input int cyc, input logic lvi_exp, input logic ret_exp);
    int n;
    fork
      u_src.fire(src, cyc);
      begin
        n = 0;
        while (sys_rst_n !== 1'b0 && n < 20) begin
          @(posedge clk);
          n++;
        end
        @(posedge clk);
        chk({port_hiz, low_pin_oe, low_pin_o}, 3'h6, "ports in reset");
        chk({xtal_en, int_osc_en}, 2'h0, "oscillators in reset");
        chk(wdt_clear, 1'b1, "watchdog clear");
        chk(lvi_clear, lvi_exp, "detector clear");
        chk(retain_hold, ret_exp, "retain in reset");
      end
    join
    boot(4096);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // HALT: masked request keeps halt, unmasked wakes, pending blocks entry
  task automatic t_halt;
    int n;
    irq_mask <= 8'hff; irq_req <= 8'h01;
    pulse(1'b0);
    repeat (2) @(posedge clk);
    chk(cpu_clk_en, 1'b0, "halted with masked request");
    irq_mask <= 8'hfe;
    wait_cpu(10, n);
    chk(cpu_clk_en, 1'b1, "unmasked request wakes");
    pulse(1'b0);
    n = 0;
    repeat (4) begin
      @(posedge clk);
      if (cpu_clk_en !== 1'b1) n++;
    end
    chk(n, 0, "halt with pending request");
    irq_req <= 8'h00;
    $display("done: halt");
  endtask

  // STOP with pending request degrades to a 256-cycle wait
  task automatic t_stop_irq;
    int n;
    apb(1'b1, rsc_pkg::OFS_WAIT_SEL, 32'h0);
    apb(1'b1, rsc_pkg::OFS_WAIT_SEL, 32'h7);
    apb(1'b0, rsc_pkg::OFS_WAIT_SEL, 32'h0);
    chk(last_rd, 32'h0, "wait select refuses 7");
    irq_mask <= 8'h00; irq_req <= 8'h02;
    pulse(1'b1);
    @(posedge clk);
    chk({cpu_clk_en, xtal_en}, 2'h1, "stop degraded, oscillator on");
    wait_cpu(400, n);
    chk(n >= 255 && n <= 264, 1'b1, "stop with pending request");
    irq_req <= 8'h00;
    $display("done: stop with request");
  endtask

  // STOP without request, then an interrupt wakes it after start-up plus 256 cycles
  task automatic t_stop_wake;
    pulse(1'b1);
    repeat (3) @(posedge clk);
    chk({xtal_en, cpu_clk_en}, 2'h0, "stopped without request");
    irq_req <= 8'h04;
    boot(256);
    irq_req <= 8'h00;
    $display("done: stop wake");
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    nrst = 1'b0; stop_exec = 1'b0; halt_exec = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    irq_req = 8'h00; irq_mask = 8'hff; paddr = 12'h000; pwdata = 32'h0;
    repeat (12) @(posedge clk);
    chk({port_hiz, low_pin_oe, low_pin_o, sys_rst_n}, 4'hc, "pins in power-up reset");
    chk({xtal_en, int_osc_en}, 2'h0, "oscillators in power-up reset");
    nrst <= 1'b1;
    boot(4096);
    apb(1'b0, rsc_pkg::OFS_WAIT_SEL, 32'h0);
    chk(last_rd, 32'h4, "wait select reset value");
    apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
    chk(last_rd, 32'h0, "cause reset value");
    apb(1'b0, 12'h010, 32'h0);
    chk(last_err, 1'b1, "unmapped read error");
    chk(last_rd, 32'h0, "unmapped read data");
    $display("done: power-up");
    t_halt();
    t_stop_irq();
    t_stop_wake();
    pulse(1'b1);
    repeat (3) @(posedge clk);
    chk({xtal_en, cpu_clk_en}, 2'h0, "stop entered");
    episode(0, 250, 1'b1, 1'b1);
    $display("done: pin reset in stop");
    episode(1, 10, 1'b1, 1'b0);
    apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
    chk(last_rd, 32'h1, "watchdog cause");
    episode(3, 10, 1'b0, 1'b0);
    apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
    chk(last_rd, 32'h5, "low-voltage cause");
    apb(1'b1, rsc_pkg::OFS_WATCH, 32'h1);
    apb(1'b1, rsc_pkg::OFS_WATCH, 32'h0);
    apb(1'b0, rsc_pkg::OFS_WATCH, 32'h0);
    chk(last_rd, 32'h1, "watch enable sticky");
    episode(2, 10, 1'b1, 1'b0);
    apb(1'b0, rsc_pkg::OFS_WATCH, 32'h0);
    chk(last_rd, 32'h0, "watch enable cleared");
    apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
    chk(last_rd, 32'h7, "clock watch cause");
    episode(4, 10, 1'b1, 1'b0);
    apb(1'b0, rsc_pkg::OFS_CAUSE, 32'h0);
    chk(last_rd, 32'h0, "power-on clear empties causes");
    $display("done: reset sources");
    stop_test();
  end

  // Cut a hang short
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule
